// *** rtl/cpuseq_pkg.sv ***
package cpuseq_pkg;
	localparam int unsigned CPUSEQ_CLKS_PER_CYCLE = 8;
	localparam logic [2:0]  CPUSEQ_PH_LAST = 3'(CPUSEQ_CLKS_PER_CYCLE - 1);
	localparam int unsigned CPUSEQ_NREG = 16;
	localparam logic [3:0]  CPUSEQ_DMA_REG = 4'h0;
	localparam logic [3:0]  CPUSEQ_IRQ_X = 4'h2;
	localparam logic [3:0]  CPUSEQ_IRQ_P = 4'h1;
	localparam logic [15:0] CPUSEQ_START_ADDR = 16'h0000;
	// high opcode digits
	localparam logic [3:0]  CPUSEQ_OP_EXT7 = 4'h7;
	localparam logic [3:0]  CPUSEQ_OP_GETLO = 4'h8;
	localparam logic [3:0]  CPUSEQ_OP_GETHI = 4'h9;
	localparam logic [3:0]  CPUSEQ_OP_PUTLO = 4'ha;
	localparam logic [3:0]  CPUSEQ_OP_PUTHI = 4'hb;
	localparam logic [3:0]  CPUSEQ_OP_LONG = 4'hc;
	localparam logic [3:0]  CPUSEQ_OP_SETP = 4'hd;
	localparam logic [3:0]  CPUSEQ_OP_SETX = 4'he;
	localparam logic [3:0]  CPUSEQ_OP_ALU = 4'hf;
	// low digits within the 7x group, plus the FE shift-left digit of the Fx group
	localparam logic [3:0]  CPUSEQ_N_SUBA_BRW = 4'hd;
	localparam logic [3:0]  CPUSEQ_N_ROTL_C = 4'he;
	localparam logic [3:0]  CPUSEQ_N_SUBM_BRW = 4'hf;
	localparam logic [3:0]  CPUSEQ_N_SHIFTL = 4'he;
	// apb map
	localparam logic [11:0] CPUSEQ_ADDR_CTRL = 12'h000;
	localparam logic [11:0] CPUSEQ_ADDR_STATUS = 12'h004;
	localparam logic [11:0] CPUSEQ_ADDR_PCVAL = 12'h008;
	localparam int unsigned CPUSEQ_CTRL_RUN_BIT = 0;
	localparam int unsigned CPUSEQ_CTRL_HOLD_BIT = 1;
	localparam logic [1:0]  CPUSEQ_CTRL_RESET = 2'h1;
	// state codes {hi, lo}
	localparam logic [1:0]  CPUSEQ_CODE_FETCH = 2'h0;
	localparam logic [1:0]  CPUSEQ_CODE_EXEC = 2'h1;
	localparam logic [1:0]  CPUSEQ_CODE_DMA = 2'h2;
	localparam logic [1:0]  CPUSEQ_CODE_IRQ = 2'h3;

	typedef enum logic [3:0] {
		fetch_cycle   = 4'b0001,
		execute_cycle = 4'b0010,
		dma_cycle     = 4'b0100,
		irq_cycle     = 4'b1000
	} cpuseq_state_type;

	typedef enum logic [3:0] {
		alu_pass, alu_load, alu_or, alu_and, alu_xor, alu_add, alu_sd,
		alu_sm, alu_shr, alu_shift_left, alu_rotl_carry, alu_sdb, alu_smb
	} cpuseq_alu_type;
endpackage

// *** rtl/cpuseq_alu.sv ***
`timescale 1ns/10ps
module cpuseq_alu
	import cpuseq_pkg::*;
(
	input  wire cpuseq_alu_type op,
	input  wire logic [7:0]     acc,
	input  wire logic [7:0]     mem,
	input  wire logic           carry_in,
	output logic [7:0]          res,
	output logic                carry_out
);
	logic [8:0] sum;

	// subtract carry out is 1 for no borrow; borrow in is the inverted carry
	always_comb begin
		sum = 9'h000;
		res = acc;
		carry_out = carry_in;
		case (op)
			alu_load: res = mem;
			alu_or: res = acc | mem;
			alu_and: res = acc & mem;
			alu_xor: res = acc ^ mem;
			alu_add: begin
				sum = {1'b0, acc} + {1'b0, mem};
				{carry_out, res} = sum;
			end
			alu_sd: begin
				sum = {1'b0, mem} + {1'b0, ~acc} + 9'h001;
				{carry_out, res} = sum;
			end
			alu_sdb: begin
				sum = {1'b0, mem} + {1'b0, ~acc} + {8'h00, carry_in};
				{carry_out, res} = sum;
			end
			alu_sm: begin
				sum = {1'b0, acc} + {1'b0, ~mem} + 9'h001;
				{carry_out, res} = sum;
			end
			alu_smb: begin
				sum = {1'b0, acc} + {1'b0, ~mem} + {8'h00, carry_in};
				{carry_out, res} = sum;
			end
			alu_shr: begin
				res = {1'b0, acc[7:1]};
				carry_out = acc[0];
			end
			alu_shift_left: begin
				res = {acc[6:0], 1'b0};
				carry_out = acc[7];
			end
			alu_rotl_carry: begin
				res = {acc[6:0], carry_in};
				carry_out = acc[7];
			end
			default: res = acc;
		endcase
	end
endmodule

// *** rtl/cpuseq_core.sv ***
// Behaviour
// RULE1: every machine cycle lasts exactly eight clocks.
// RULE2: instruction is one fetch plus one or two execute cycles.
// RULE3: state code LL fetch, LH execute, HL dma, HH interrupt.
// RULE4: dma or interrupt cycle inserted after last execute, before fetch.
// RULE5: clear low holds reset; on release one init cycle coded execute.
// RULE6: first fetch from address zero; interrupts disabled during init.
// RULE7: cycle after init may be dma, never interrupt.
// RULE8: wait low freezes current state; wait high resumes it.
// RULE9: long branches take three cycles, three bytes; C0 always, C1 flag.
// RULE10: C4-C8, CC-CF one byte three cycles, no-op, C8 unconditional skip, rest conditional skips.
// RULE11: DN loads program designator, EN data designator; two cycles.
// RULE12: 8N/9N read register byte to acc; AN/BN write acc to it.
// RULE13: F0-F7 load or alu op with byte at data pointer.
// RULE14: F8-FD, FF immediate forms; FE shift left one byte.
// RULE15: 7D sub-d borrow imm, 7E rotate left carry, 7F sub-mem borrow.
// RULE16: carry set on add carry; after subtract set means no borrow.
// RULE17: interrupt saves data and program designators into holding byte.
// RULE18: one-bit interrupt enable, output flag and carry flops.
// RULE19: sixteen 16-bit registers, 8-bit acc, two 4-bit designators.
// RULE20: opcode split into high digit and low digit registers.
// RULE21: true long skip advances program counter past two bytes.
// RULE22: fetch reads byte at program counter then increments it.
`timescale 1ns/10ps
module cpuseq_core
	import cpuseq_pkg::*;
#(
	parameter int unsigned APB_AW = 12
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [APB_AW-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              clear_n,
	input  wire logic              wait_n,
	input  wire logic              dma_req,
	input  wire logic              irq_req,
	input  wire logic [7:0]        mem_rdata,
	output logic      [15:0]       mem_addr,
	output logic                   mem_rd,
	output logic                   cycle_type_out_hi,
	output logic                   cycle_type_out_lo,
	output logic                   q_out
);
	logic [15:0]      r [CPUSEQ_NREG];
	logic [7:0]       d;
	logic [7:0]       t;
	logic [7:0]       b;
	logic [3:0]       p;
	logic [3:0]       x;
	logic [3:0]       i;
	logic [3:0]       n;
	logic             carry_flag;
	logic             irq_enable_flop;
	logic             q;
	logic [2:0]       ph;
	logic             init;
	logic             exe2;
	logic             ctrl_run;
	logic             ctrl_hold;
	cpuseq_state_type st;
	cpuseq_state_type next_st;
	cpuseq_alu_type   alu_op;
	logic [7:0]       alu_res;
	logic             alu_c;
	logic             alu_we;
	logic             run;
	logic             go;
	logic             tick;
	logic             irq_ok;
	logic             last_exec;
	logic [15:0]      cur;
	logic [15:0]      addr_sel;
	logic             wen;
	logic [3:0]       widx;
	logic [15:0]      wdata;
	logic             setup;
	logic [31:0]      rd_mux;
	logic             mapped;

	function automatic cpuseq_state_type after_instr(input logic dma,
		input logic irq);
		if (dma)
			return dma_cycle;
		else if (irq)
			return irq_cycle;
		return fetch_cycle;
	endfunction

	function automatic logic [1:0] code_of(input cpuseq_state_type s);
		case (s)
			fetch_cycle: return CPUSEQ_CODE_FETCH;
			execute_cycle: return CPUSEQ_CODE_EXEC;
			dma_cycle: return CPUSEQ_CODE_DMA;
			irq_cycle: return CPUSEQ_CODE_IRQ;
			default: return CPUSEQ_CODE_EXEC;
		endcase
	endfunction

	// low digit 8 is the unconditional skip, not a branch
	function automatic logic is_branch(input logic [3:0] lo);
		return !lo[2] && lo != 4'h8;
	endfunction

	function automatic logic branch_true(input logic [3:0] lo,
		input logic fq, input logic [7:0] acc, input logic cf);
		logic base;
		base = 1'b1;
		case (lo[1:0])
			2'h1: base = fq;
			2'h2: base = acc == 8'h00;
			2'h3: base = cf;
			default: base = 1'b1;
		endcase
		return base ^ lo[3];
	endfunction

	function automatic logic skip_true(input logic [3:0] lo,
		input logic fq, input logic [7:0] acc, input logic cf,
		input logic ie);
		case (lo)
			4'h5: return !fq;
			4'h6: return acc != 8'h00;
			4'h7: return !cf;
			4'h8: return 1'b1;
			4'hc: return ie;
			4'hd: return fq;
			4'he: return acc == 8'h00;
			4'hf: return cf;
			default: return 1'b0;
		endcase
	endfunction

	assign run = clear_n && ctrl_run;
	assign go = run && wait_n && !ctrl_hold; // RULE8
	assign tick = go && ph == CPUSEQ_PH_LAST; // RULE1
	assign irq_ok = irq_req && irq_enable_flop;
	assign cur = r[p];
	assign q_out = q;
	// opcodes outside this decoder run as one-execute no-ops
	assign last_exec = init || i != CPUSEQ_OP_LONG || exe2; // RULE2 RULE9

	always_comb begin
		alu_op = alu_pass;
		alu_we = 1'b0;
		if (i == CPUSEQ_OP_EXT7) begin
			alu_we = n >= CPUSEQ_N_SUBA_BRW;
			case (n)
				CPUSEQ_N_SUBA_BRW: alu_op = alu_sdb; // RULE15
				CPUSEQ_N_ROTL_C: alu_op = alu_rotl_carry;
				CPUSEQ_N_SUBM_BRW: alu_op = alu_smb;
				default: alu_op = alu_pass;
			endcase
		end else if (i == CPUSEQ_OP_ALU) begin
			alu_we = 1'b1;
			case (n[2:0]) // RULE13 RULE14
				3'h0: alu_op = alu_load;
				3'h1: alu_op = alu_or;
				3'h2: alu_op = alu_and;
				3'h3: alu_op = alu_xor;
				3'h4: alu_op = alu_add;
				3'h5: alu_op = alu_sd;
				3'h6: alu_op = n[3] ? alu_shift_left : alu_shr;
				default: alu_op = alu_sm;
			endcase
		end
	end

	cpuseq_alu u_alu (
		.op        (alu_op),
		.acc       (d),
		.mem       (mem_rdata),
		.carry_in  (carry_flag),
		.res       (alu_res),
		.carry_out (alu_c)
	);

	// operand address: data pointer for F0-F7, register 0 in dma cycles, else program counter
	always_comb begin
		case (st)
			execute_cycle: addr_sel = (i == CPUSEQ_OP_ALU && !n[3])
				? r[x] : cur;
			dma_cycle: addr_sel = r[CPUSEQ_DMA_REG];
			default: addr_sel = cur;
		endcase
	end

	always_comb begin
		wen = 1'b0;
		widx = p;
		wdata = cur + 16'h0001;
		if (tick) begin
			case (st)
				fetch_cycle: wen = 1'b1; // RULE22
				dma_cycle: begin
					wen = 1'b1;
					widx = CPUSEQ_DMA_REG;
					wdata = r[CPUSEQ_DMA_REG] + 16'h0001;
				end
				execute_cycle: begin
					if (init) begin
						wen = 1'b1; // RULE6
						widx = CPUSEQ_DMA_REG;
						wdata = CPUSEQ_START_ADDR;
					end else if (i == CPUSEQ_OP_PUTLO) begin
						wen = 1'b1; // RULE12
						widx = n;
						wdata = {r[n][15:8], d};
					end else if (i == CPUSEQ_OP_PUTHI) begin
						wen = 1'b1;
						widx = n;
						wdata = {d, r[n][7:0]};
					end else if (i == CPUSEQ_OP_EXT7) begin
						wen = n == CPUSEQ_N_SUBA_BRW
							|| n == CPUSEQ_N_SUBM_BRW;
					end else if (i == CPUSEQ_OP_ALU) begin
						wen = n[3] && n != CPUSEQ_N_SHIFTL;
					end else if (i == CPUSEQ_OP_LONG) begin
						if (is_branch(n)) begin
							wen = 1'b1; // RULE9
							if (exe2 && branch_true(n, q, d, carry_flag))
								wdata = {b, mem_rdata};
						end else if (exe2) begin
							wen = skip_true(n, q, d, carry_flag,
								irq_enable_flop); // RULE10 RULE21
							wdata = cur + 16'h0002;
						end
					end
				end
				default: wen = 1'b0;
			endcase
		end
	end

	genvar g;
	generate
		for (g = 0; g < CPUSEQ_NREG; g++) begin : g_reg
			always_ff @(posedge pclk or negedge presetn) begin // RULE19
				if (!presetn)
					r[g] <= 16'h0000;
				else if (wen && widx == 4'(g))
					r[g] <= wdata;
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ph <= 3'h0;
		else if (!run)
			ph <= 3'h0;
		else if (go)
			ph <= ph + 3'h1; // RULE1
	end

	always_comb begin
		next_st = st;
		if (!run) begin
			next_st = execute_cycle; // RULE5
		end else if (tick) begin
			case (st)
				fetch_cycle: next_st = execute_cycle;
				execute_cycle: if (last_exec)
					next_st = after_instr(dma_req, irq_ok && !init); // RULE4 RULE7
				dma_cycle: next_st = after_instr(dma_req, irq_ok);
				irq_cycle: next_st = after_instr(dma_req, 1'b0);
				default: next_st = fetch_cycle;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= execute_cycle;
			{cycle_type_out_hi, cycle_type_out_lo} <= CPUSEQ_CODE_EXEC;
		end else begin
			st <= next_st;
			{cycle_type_out_hi, cycle_type_out_lo} <= code_of(next_st); // RULE3
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init <= 1'b1;
			exe2 <= 1'b0;
		end else if (!run) begin
			init <= 1'b1;
			exe2 <= 1'b0;
		end else if (tick) begin
			if (st == execute_cycle) begin
				init <= 1'b0;
				exe2 <= !last_exec;
			end else begin
				exe2 <= 1'b0;
			end
		end
	end

	// mem_addr lags the cycle by one clock; data is taken on the last one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_addr <= 16'h0000;
			mem_rd <= 1'b0;
		end else if (!run) begin
			mem_rd <= 1'b0;
		end else if (go) begin
			mem_addr <= addr_sel;
			mem_rd <= st == fetch_cycle || (st == execute_cycle && !init);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin // RULE18
		if (!presetn) begin
			p <= 4'h0;
			x <= 4'h0;
			irq_enable_flop <= 1'b0;
			q <= 1'b0;
			t <= 8'h00;
		end else if (!run) begin
			p <= 4'h0; // RULE6
			x <= 4'h0;
			irq_enable_flop <= 1'b0;
			q <= 1'b0;
		end else if (tick) begin
			if (st == irq_cycle) begin
				t <= {x, p}; // RULE17
				x <= CPUSEQ_IRQ_X;
				p <= CPUSEQ_IRQ_P;
				irq_enable_flop <= 1'b0;
			end else if (st == execute_cycle && init) begin
				irq_enable_flop <= 1'b1;
			end else if (st == execute_cycle) begin
				if (i == CPUSEQ_OP_SETP)
					p <= n; // RULE11
				if (i == CPUSEQ_OP_SETX)
					x <= n;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			i <= 4'h0;
			n <= 4'h0;
			d <= 8'h00;
			b <= 8'h00;
			carry_flag <= 1'b0;
		end else if (tick && st == fetch_cycle) begin
			{i, n} <= mem_rdata; // RULE20
		end else if (tick && st == execute_cycle && !init) begin
			if (i == CPUSEQ_OP_GETLO)
				d <= r[n][7:0]; // RULE12
			if (i == CPUSEQ_OP_GETHI)
				d <= r[n][15:8];
			if (i == CPUSEQ_OP_LONG && !exe2)
				b <= mem_rdata;
			if (alu_we) begin
				d <= alu_res;
				carry_flag <= alu_c; // RULE16
			end
		end
	end

	// zero-wait apb slave; read data captured in the setup cycle
	assign pready = 1'b1;
	assign setup = psel && !penable;
	always_comb begin
		mapped = 1'b1;
		case (paddr)
			CPUSEQ_ADDR_CTRL: rd_mux = {30'h0, ctrl_hold, ctrl_run};
			CPUSEQ_ADDR_STATUS: rd_mux = {9'h000, code_of(st), init,
				exe2, irq_enable_flop, q, carry_flag, x, p, d};
			CPUSEQ_ADDR_PCVAL: rd_mux = {8'h00, t, cur};
			default: begin
				rd_mux = 32'h0;
				mapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= pwrite ? 32'h0 : rd_mux;
			pslverr <= !mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{ctrl_hold, ctrl_run} <= CPUSEQ_CTRL_RESET;
		end else if (psel && penable && pwrite
			&& paddr == CPUSEQ_ADDR_CTRL) begin
			ctrl_run <= pwdata[CPUSEQ_CTRL_RUN_BIT];
			ctrl_hold <= pwdata[CPUSEQ_CTRL_HOLD_BIT];
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [8:0] add9;
	assign add9 = {1'b0, d} + {1'b0, mem_rdata};

	property p_cycle_len;
		st != $past(st) |-> $past(ph) == 3'h7 || !$past(run);
	endproperty
	a_cycle_len: assert property (p_cycle_len) // RULE1
		else $error("state changed mid machine cycle");

	property p_two_exec;
		tick && st == execute_cycle && exe2 |=> st != execute_cycle;
	endproperty
	a_two_exec: assert property (p_two_exec) // RULE2
		else $error("more than two execute cycles");

	property p_code;
		run ##1 run |-> {cycle_type_out_hi, cycle_type_out_lo}
			== code_of(st);
	endproperty
	a_code: assert property (p_code) // RULE3
		else $error("state code does not match cycle type");

	property p_dma_insert;
		tick && st == execute_cycle && last_exec && dma_req && run
			|=> st == dma_cycle;
	endproperty
	a_dma_insert: assert property (p_dma_insert) // RULE4
		else $error("dma request not served after instruction");

	property p_reset_hold;
		!run |=> st == execute_cycle && init && ph == 3'h0;
	endproperty
	a_reset_hold: assert property (p_reset_hold) // RULE5
		else $error("reset mode not holding init state");

	property p_init_ie;
		init |-> !irq_enable_flop;
	endproperty
	a_init_ie: assert property (p_init_ie) // RULE6
		else $error("interrupts enabled during init");

	property p_no_irq_after_init;
		tick && init |=> st != irq_cycle;
	endproperty
	a_no_irq_after_init: assert property (p_no_irq_after_init) // RULE7
		else $error("interrupt cycle right after init");

	property p_pause;
		run && !go |=> st == $past(st) && ph == $past(ph);
	endproperty
	a_pause: assert property (p_pause) // RULE8
		else $error("state moved while paused");

	property p_setp;
		tick && st == execute_cycle && !init && i == CPUSEQ_OP_SETP
			|=> p == $past(n);
	endproperty
	a_setp: assert property (p_setp) // RULE11
		else $error("program designator not loaded");

	property p_add_carry;
		tick && st == execute_cycle && !init && i == CPUSEQ_OP_ALU
			&& n[2:0] == 3'h4 |=> carry_flag == $past(add9[8]);
	endproperty
	a_add_carry: assert property (p_add_carry) // RULE16
		else $error("add carry wrong");

	property p_irq_save;
		tick && st == irq_cycle |=> t == {$past(x), $past(p)}
			&& !irq_enable_flop;
	endproperty
	a_irq_save: assert property (p_irq_save) // RULE17
		else $error("interrupt did not save designators");

	property p_fetch_inc;
		tick && st == fetch_cycle |=> cur == $past(cur) + 16'h0001;
	endproperty
	a_fetch_inc: assert property (p_fetch_inc) // RULE22
		else $error("program counter not incremented on fetch");

	c_dma: cover property (tick && st == dma_cycle);
	c_irq: cover property (tick && st == irq_cycle);
	c_long_taken: cover property (tick && st == execute_cycle && exe2
		&& is_branch(n) && branch_true(n, q, d, carry_flag));
	c_pause: cover property (run && !go && st == fetch_cycle);
endmodule

// *** sim/cpuseq_mem_model.sv ***
`timescale 1ns/10ps
module cpuseq_mem_model (
	input  wire logic        pclk,
	input  wire logic        slow,
	input  wire logic [15:0] mem_addr,
	input  wire logic        mem_rd,
	output logic      [7:0]  mem_rdata
);
	logic [7:0]  image [256];
	logic [7:0]  last;
	logic [15:0] seen_addr;
	logic [2:0]  age;
	logic [7:0]  prog [45] = '{
		8'hf8, 8'h05, 8'hc4, 8'hc8, 8'h00, 8'h00, 8'hc6, 8'h00, 8'h00,
		8'hfc, 8'hfb, 8'hcf, 8'h00, 8'h00, 8'hc6, 8'hc5, 8'h00, 8'h00,
		8'hc1, 8'h00, 8'h00, 8'hc0, 8'h00, 8'h18, 8'hff, 8'h01, 8'hc7,
		8'h00, 8'h00, 8'hf8, 8'h00, 8'hb3, 8'hb1, 8'hf8, 8'h30, 8'ha3,
		8'hf8, 8'h40, 8'ha1, 8'h83, 8'hc6, 8'h00, 8'h00, 8'he5, 8'hd3
	};

	initial begin
		for (int i = 0; i < 256; i++) begin
			image[i] = (i < 45) ? prog[i] : 8'hc4;
		end
		// two endless long-branch loops
		{image[8'h30], image[8'h31], image[8'h32]} = 24'hc00030;
		{image[8'h40], image[8'h41], image[8'h42]} = 24'hc00040;
		last = 8'h00;
		seen_addr = 16'h0000;
		age = 3'd0;
	end

	// slow mode: data only after four stable clocks, never stale before
	always @(posedge pclk) begin
		if (mem_addr !== seen_addr) begin
			age <= 3'd0;
		end else if (age != 3'd7) begin
			age <= age + 3'd1;
		end
		seen_addr <= mem_addr;
		last <= mem_rdata;
	end

	// undriven bus toggles each clock so a stale sample cannot pass
	assign mem_rdata = (mem_rd === 1'b1 && (!slow || age >= 3'd4)) ?
		image[mem_addr[7:0]] : ~last;
endmodule

// *** sim/test_cpu_opcode_state_sequencer.sv ***
`timescale 1ns/10ps
module test_cpu_opcode_state_sequencer;
	import cpuseq_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        clear_n, wait_n, dma_req, irq_req, mem_rd, slow, held;
	logic [7:0]  mem_rdata;
	logic [15:0] mem_addr;
	logic        cycle_type_out_hi, cycle_type_out_lo, q_out;
	logic [1:0]  code, prev_code;
	logic [20:0] cur;
	logic [20:0] q [$];
	int          n_errors, comparisons, run_len, cycles;
	bit          skip, pend;
	logic [7:0]  fa [25] = '{8'h00, 8'h02, 8'h03, 8'h06, 8'h09, 8'h0b,
		8'h0e, 8'h0f, 8'h12, 8'h15, 8'h18, 8'h1a, 8'h1d, 8'h1f, 8'h20,
		8'h21, 8'h23, 8'h24, 8'h26, 8'h27, 8'h28, 8'h2b, 8'h2c, 8'h30,
		8'h30};
	logic [1:0]  fe [25] = '{1, 1, 2, 2, 2, 1, 2, 2, 2, 2, 2, 1, 2, 1, 1,
		1, 1, 1, 1, 1, 1, 2, 1, 1, 2};

	assign code = {cycle_type_out_hi, cycle_type_out_lo};

	cpuseq_core #(.APB_AW(12)) uut (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .clear_n(clear_n), .wait_n(wait_n),
		.dma_req(dma_req), .irq_req(irq_req), .mem_rdata(mem_rdata),
		.mem_addr(mem_addr), .mem_rd(mem_rd),
		.cycle_type_out_hi(cycle_type_out_hi),
		.cycle_type_out_lo(cycle_type_out_lo), .q_out(q_out));

	cpuseq_mem_model mem (.pclk(pclk), .slow(slow), .mem_addr(mem_addr),
		.mem_rd(mem_rd), .mem_rdata(mem_rdata));

	always #20 pclk = ~pclk;

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_code(input logic [1:0] c);
		int n;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (code !== c && n < 400);
		@(posedge pclk);
	endtask

	task automatic wait_empty;
		int n;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (q.size() != 0 && n < 3000);
		@(posedge pclk);
	endtask

	// each new non-execute cycle takes the oldest note
	always @(negedge pclk) begin
		if (pend) begin
			pend = 0;
			if (!cur[20]) check("cycle address", mem_addr, cur[15:0]);
		end
		if (presetn !== 1'b1 || clear_n !== 1'b1) begin
			run_len = 0;
			skip = 1;
			prev_code = CPUSEQ_CODE_EXEC;
		end else if (code !== prev_code) begin
			if (!skip) check("cycle length", run_len % 8, 0);
			if (code !== CPUSEQ_CODE_EXEC && q.size() > 0) begin
				cur = q.pop_front();
				check("cycle code", code, cur[19:18]);
				check("executes", (prev_code === CPUSEQ_CODE_EXEC) ?
					run_len / 8 : 0, cur[17:16]);
				pend = 1;
			end
			prev_code = code;
			run_len = 1;
			skip = 0;
		end else begin
			run_len++;
		end
		if (wait_n === 1'b0 || held) skip = 1;
	end

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			wrap_up();
		end
	end

	initial begin
		logic [31:0] r;
		logic        e;
		pclk = 0;
		presetn = 0;
		clear_n = 0;
		wait_n = 1;
		dma_req = 0;
		irq_req = 1;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		slow = 0;
		held = 0;
		void'($urandom(32'h76fe));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(negedge pclk);
		check("reset code", code, CPUSEQ_CODE_EXEC);
		check("reset strobe", mem_rd, 1'b0);
		apb(0, CPUSEQ_ADDR_CTRL, 0, r, e);
		check("ctrl reset", r[1:0], CPUSEQ_CTRL_RESET);
		apb(0, {10'($urandom_range(1023, 3)), 2'b00}, 0, r, e);
		check("unmapped error", e, 1'b1);
		check("unmapped data", r, 0);
		for (int i = 0; i < 25; i++) begin
			q.push_back({1'b0, CPUSEQ_CODE_FETCH, fe[i], 8'h00, fa[i]});
		end
		// interrupt held through init must not be served
		clear_n <= 1'b1;
		wait_code(CPUSEQ_CODE_FETCH);
		irq_req <= 1'b0;
		wait_empty;
		slow <= 1'b1;
		q.push_back({1'b0, CPUSEQ_CODE_DMA, 2'd2, 16'h002d});
		q.push_back({1'b0, CPUSEQ_CODE_FETCH, 2'd0, 16'h0030});
		dma_req <= 1'b1;
		wait_code(CPUSEQ_CODE_DMA);
		dma_req <= 1'b0;
		wait_empty;
		q.push_back({1'b1, CPUSEQ_CODE_IRQ, 2'd2, 16'h0000});
		q.push_back({1'b0, CPUSEQ_CODE_FETCH, 2'd0, 16'h0040});
		irq_req <= 1'b1;
		wait_code(CPUSEQ_CODE_IRQ);
		irq_req <= 1'b0;
		wait_empty;
		apb(0, CPUSEQ_ADDR_PCVAL, 0, r, e);
		check("saved designators", r[23:16], 8'h53);
		wait_code(CPUSEQ_CODE_FETCH);
		q.push_back({1'b0, CPUSEQ_CODE_FETCH, 2'd2, 16'h0040});
		wait_n <= 1'b0;
		repeat (5'($urandom_range(20, 4))) begin
			@(negedge pclk);
			check("paused code", code, CPUSEQ_CODE_FETCH);
			check("paused address", mem_addr, 16'h0040);
			@(posedge pclk);
		end
		wait_n <= 1'b1;
		wait_empty;
		held = 1'b1;
		apb(1, CPUSEQ_ADDR_CTRL, 32'h3, r, e);
		apb(0, CPUSEQ_ADDR_CTRL, 0, r, e);
		check("ctrl readback", r[1:0], 2'h3);
		apb(1, CPUSEQ_ADDR_CTRL, 32'h1, r, e);
		held = 1'b0;
		clear_n <= 1'b0;
		repeat (4) @(negedge pclk);
		check("clear code", code, CPUSEQ_CODE_EXEC);
		@(posedge pclk);
		// dma may take the cycle right after init
		q.push_back({1'b0, CPUSEQ_CODE_DMA, 2'd1, 16'h0000});
		q.push_back({1'b0, CPUSEQ_CODE_FETCH, 2'd0, 16'h0001});
		dma_req <= 1'b1;
		clear_n <= 1'b1;
		wait_code(CPUSEQ_CODE_DMA);
		dma_req <= 1'b0;
		wait_empty;
		check("notes left", q.size(), 0);
		check("output flag", q_out, 1'b0);
		wrap_up();
	end
endmodule
